// >>> rtl/acd_discard.sv
// The Wishbone interface to the registers was chosen for this implementation.
module acd_discard #(
  parameter int unsigned NQ    = 64,
  parameter int unsigned PTR_W = 19
) (
  // System
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Wishbone slave
  input  acd_pkg::acd_wb_req_type    wb_i,
  output logic [31:0]                wb_dat_o,
  output logic                       wb_ack_o,
  // Arriving cells
  input  wire logic                  rx_valid_i,
  input  acd_pkg::acd_cell_type      rx_cell_i,
  input  wire logic [7:0]            phy_fill_i,
  output logic                       rx_ready_o,
  output logic                       rx_valid_o,
  output logic                       rx_drop_o,
  output acd_pkg::acd_cell_type      rx_cell_o,
  // Departing cells
  input  wire logic                  tx_valid_i,
  input  acd_pkg::acd_cell_type      tx_cell_i,
  output logic                       tx_ready_o,
  output logic                       tx_valid_o,
  output logic [63:0]                tx_hdr_o
);
  import acd_pkg::*;

  localparam int QW = $clog2(NQ);

  logic [15:0]          main_q;
  logic [SEL_W-1:0]     sel_q [SEL_N];
  logic                 ppd_pend_q;
  logic                 ppd_val_q;
  logic [PPD_PTR_W-1:0] ppd_addr_q;
  logic [15:0]          pmem [PMEM_WORDS];
  acd_qctl_type         qctl_q [NQ];
  logic [PTR_W-1:0]     qbase_q [NQ];
  logic [PTR_W-1:0]     qend_q [NQ];
  logic [PTR_W-1:0]     qclp_q [NQ];
  logic [PTR_W-1:0]     qfecn_q [NQ];
  logic [PTR_W-1:0]     qrd_q [NQ];
  logic [PTR_W-1:0]     qwr_q [NQ];

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old_v & ~m) | (new_v & m);
  endfunction

  // Cells held between read and write pointer, wrapping at the queue end
  function automatic logic [PTR_W-1:0] occ(input logic [PTR_W-1:0] b, input logic [PTR_W-1:0] e,
                                           input logic [PTR_W-1:0] r, input logic [PTR_W-1:0] w);
    return (w >= r) ? PTR_W'(w - r) : PTR_W'(e - b + w - r + 1'b1);
  endfunction

  function automatic logic [PTR_W-1:0] next_ptr(input logic [PTR_W-1:0] p,
                                                input logic [PTR_W-1:0] b,
                                                input logic [PTR_W-1:0] e);
    return (p == e) ? b : PTR_W'(p + 1'b1);
  endfunction

  // Bus decode
  wire              req      = wb_i.cyc & wb_i.stb;
  wire [13:0]       idx      = wb_i.adr[15:2];
  wire              wr_go    = req & wb_i.we & wb_ack_o;
  wire              hit_main = idx == MAIN_IDX;
  wire              hit_info = idx >= INFO_IDX && idx <= INFO_LAST && !idx[0];
  wire              hit_pwr  = idx == PWR_IDX;
  wire [13:0]       qc_off   = 14'(idx - QCTL_IDX);
  wire [QW-1:0]     qc_sel   = qc_off[QW:1];
  wire              hit_qctl = idx >= QCTL_IDX && idx <= QCTL_LAST && !idx[0]
                               && 32'(qc_off[13:1]) < NQ;
  wire [13:0]       pm_off   = 14'(idx - PMEM_IDX);
  wire [8:0]        pm_word  = pm_off[9:1];
  wire              hit_pmem = idx >= PMEM_IDX && idx <= PMEM_LAST && !idx[0];
  wire [13:0]       qd_off   = 14'(idx - QDEF_IDX);
  wire [QW-1:0]     qd_sel   = qd_off[QW+2:3];
  wire [2:0]        qd_fld   = idx[2:0];
  wire              hit_qdef = idx >= QDEF_IDX && 32'(qd_off[13:3]) < NQ && qd_fld <= QF_WRP;
  wire [13:0]       in_off   = 14'(idx - INFO_IDX);
  wire [2:0]        info_n   = in_off[3:1];
  wire [3:0]        sel_lo   = {info_n, 1'b0};
  wire [3:0]        sel_hi   = {info_n, 1'b1};

  wire [31:0] info_rd = {16'h0, 2'h0, sel_q[sel_hi], 2'h0, sel_q[sel_lo]};
  wire [31:0] pwr_rd  = {17'h0, ppd_pend_q, ppd_val_q, ppd_addr_q};
  wire [31:0] pwr_wr  = merge(pwr_rd, wb_i.dat, wb_i.sel);
  wire [PTR_W-1:0] qd_val =
    qd_fld == QF_BASE ? qbase_q[qd_sel] :
    qd_fld == QF_END  ? qend_q[qd_sel]  :
    qd_fld == QF_CLP  ? qclp_q[qd_sel]  :
    qd_fld == QF_FECN ? qfecn_q[qd_sel] :
    qd_fld == QF_RDP  ? qrd_q[qd_sel]   : qwr_q[qd_sel];
  wire [31:0] rd_mux =
    hit_main ? {16'h0, main_q} :
    hit_info ? info_rd :
    hit_pwr  ? pwr_rd :
    hit_qctl ? {26'h0, qctl_q[qc_sel]} :
    hit_pmem ? {16'h0, pmem[pm_word]} :
    hit_qdef ? 32'(qd_val) : 32'h0000_0000;

  // One wait state; unmapped reads answer zero, unmapped writes are ignored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
      wb_dat_o <= (req & ~wb_ack_o) ? rd_mux : 32'h0000_0000;
    end
  end

  // Arrival decision
  wire              rx_take   = rx_valid_i & rx_ready_o;
  wire [63:0]       rh        = rx_cell_i.hdr;
  wire [QW-1:0]     aq        = rx_cell_i.queue[QW-1:0];
  wire              a_sdram   = ~rx_cell_i.to_phy;
  acd_qctl_type     actl;
  assign actl = qctl_q[aq];
  wire [PTR_W-1:0]  a_occ     = occ(qbase_q[aq], qend_q[aq], qrd_q[aq], qwr_q[aq]);
  wire              a_clp_hit = (qclp_q[aq] == '0) | (a_occ > qclp_q[aq]);
  wire              a_fec_hit = (qfecn_q[aq] == '0) | (a_occ > qfecn_q[aq]);
  // A full queue must not overrun its read pointer
  wire              a_full    = a_occ == PTR_W'(qend_q[aq] - qbase_q[aq]);
  wire              phy_drop  = main_q[MAIN_EN_B] & rh[HDR_CLP_B]
                                & (phy_fill_i > main_q[MAIN_LIM_W-1:0]);
  wire              q_drop    = ~actl.wr_en | a_full
                                | (actl.clp_en & rh[HDR_CLP_B] & a_clp_hit);
  wire              base_drop = rx_cell_i.to_phy ? phy_drop : q_drop;

  // Partial packet discard
  logic [PPD_PTR_W-1:0] ppd_ptr;
  for (genvar i = 0; i < PPD_PTR_W; i++) begin : g_ptr
    assign ppd_ptr[i] = rh[sel_q[i+1]];
  end
  wire              ppd_en    = rh[sel_q[0]];
  wire              ppd_state = pmem[ppd_ptr[12:4]][ppd_ptr[3:0]];
  wire              last_cell = rh[HDR_SDU_B];
  wire              ppd_drop  = ppd_en & ppd_state & ~last_cell;
  wire              cell_drop = base_drop | ppd_drop;
  wire              ppd_set   = rx_take & ppd_en & ~ppd_state & base_drop & ~last_cell;
  wire              ppd_clr   = rx_take & ppd_en & ppd_state & last_cell;
  wire              a_store   = rx_take & a_sdram & ~cell_drop;

  // Arrivals wait one cycle for a software write so the memory has one writer
  assign rx_ready_o = ~ppd_pend_q;

  // Departure
  wire              tx_take   = tx_valid_i & tx_ready_o;
  wire [QW-1:0]     dq        = tx_cell_i.queue[QW-1:0];
  acd_qctl_type     dctl;
  assign dctl = qctl_q[dq];
  wire [PTR_W-1:0]  d_occ     = occ(qbase_q[dq], qend_q[dq], qrd_q[dq], qwr_q[dq]);
  wire              d_mark    = dctl.fecn_en
                                & ~tx_cell_i.hdr[HDR_MGMT_B]
                                & (d_occ > qfecn_q[dq]);
  assign tx_ready_o = dctl.rd_en;

  // Global configuration
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      main_q     <= MAIN_RST;
      ppd_pend_q <= 1'b0;
      ppd_val_q  <= 1'b0;
      ppd_addr_q <= '0;
      for (int i = 0; i < SEL_N; i++) begin
        sel_q[i] <= '0;
      end
    end else begin
      ppd_pend_q <= 1'b0;
      if (wr_go && hit_main) begin
        main_q <= 16'(merge({16'h0, main_q}, wb_i.dat, wb_i.sel));
      end
      if (wr_go && hit_info) begin
        sel_q[sel_lo] <= SEL_W'(merge(info_rd, wb_i.dat, wb_i.sel));
        sel_q[sel_hi] <= SEL_W'(merge(info_rd, wb_i.dat, wb_i.sel) >> 8);
      end
      if (wr_go && hit_pwr) begin
        ppd_addr_q <= pwr_wr[PPD_PTR_W-1:0];
        ppd_val_q  <= pwr_wr[PW_VAL_B];
        ppd_pend_q <= pwr_wr[PW_PUL_B];
      end
    end
  end

  // Discard state memory; contents are undefined until software clears them
  always_ff @(posedge clk_i) begin
    if (ppd_set || ppd_clr) begin
      pmem[ppd_ptr[12:4]][ppd_ptr[3:0]] <= ppd_set;
    end else if (ppd_pend_q) begin
      pmem[ppd_addr_q[12:4]][ppd_addr_q[3:0]] <= ppd_val_q;
    end
  end

  // Per-queue control, flags set by cells win over a clear by software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NQ; i++) begin
        qctl_q[i] <= '0;
      end
    end else begin
      if (wr_go && hit_qctl) begin
        qctl_q[qc_sel].rd_en   <= wb_i.sel[0] ? wb_i.dat[0] : qctl_q[qc_sel].rd_en;
        qctl_q[qc_sel].wr_en   <= wb_i.sel[0] ? wb_i.dat[1] : qctl_q[qc_sel].wr_en;
        qctl_q[qc_sel].clp_en  <= wb_i.sel[0] ? wb_i.dat[2] : qctl_q[qc_sel].clp_en;
        qctl_q[qc_sel].fecn_en <= wb_i.sel[0] ? wb_i.dat[3] : qctl_q[qc_sel].fecn_en;
        if (wb_i.sel[0] && wb_i.dat[4]) begin
          qctl_q[qc_sel].clp_hit <= 1'b0;
        end
        if (wb_i.sel[0] && wb_i.dat[5]) begin
          qctl_q[qc_sel].fecn_hit <= 1'b0;
        end
      end
      if (rx_take && a_sdram && a_clp_hit) begin
        qctl_q[aq].clp_hit <= 1'b1;
      end
      if (rx_take && a_sdram && a_fec_hit) begin
        qctl_q[aq].fecn_hit <= 1'b1;
      end
    end
  end

  // Queue definitions and pointers; software writes override cell traffic
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NQ; i++) begin
        qbase_q[i] <= '0;
        qend_q[i]  <= '0;
        qclp_q[i]  <= '0;
        qfecn_q[i] <= '0;
        qrd_q[i]   <= '0;
        qwr_q[i]   <= '0;
      end
    end else begin
      if (a_store) begin
        qwr_q[aq] <= next_ptr(qwr_q[aq], qbase_q[aq], qend_q[aq]);
      end
      if (tx_take) begin
        qrd_q[dq] <= next_ptr(qrd_q[dq], qbase_q[dq], qend_q[dq]);
      end
      if (wr_go && hit_qdef) begin
        unique case (qd_fld)
          QF_BASE: qbase_q[qd_sel] <= PTR_W'(merge(32'(qd_val), wb_i.dat, wb_i.sel));
          QF_END:  qend_q[qd_sel]  <= PTR_W'(merge(32'(qd_val), wb_i.dat, wb_i.sel));
          QF_CLP:  qclp_q[qd_sel]  <= PTR_W'(merge(32'(qd_val), wb_i.dat, wb_i.sel));
          QF_FECN: qfecn_q[qd_sel] <= PTR_W'(merge(32'(qd_val), wb_i.dat, wb_i.sel));
          QF_RDP:  qrd_q[qd_sel]   <= PTR_W'(merge(32'(qd_val), wb_i.dat, wb_i.sel));
          default: qwr_q[qd_sel]   <= PTR_W'(merge(32'(qd_val), wb_i.dat, wb_i.sel));
        endcase
      end
    end
  end

  // Cell outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_valid_o <= 1'b0;
      rx_drop_o  <= 1'b0;
      rx_cell_o  <= '0;
      tx_valid_o <= 1'b0;
      tx_hdr_o   <= 64'h0;
    end else begin
      rx_valid_o <= rx_take;
      rx_drop_o  <= rx_take & cell_drop;
      rx_cell_o  <= rx_take ? rx_cell_i : rx_cell_o;
      tx_valid_o <= tx_take;
      tx_hdr_o   <= tx_take ? (tx_cell_i.hdr | (64'(d_mark) << HDR_EFCI_B)) : tx_hdr_o;
    end
  end

  // Checks
  property p_clp_drop;
    @(posedge clk_i) disable iff (rst_i)
      (rx_take && a_sdram && actl.clp_en && rh[HDR_CLP_B] && a_clp_hit) |=> rx_drop_o;
  endproperty
  a_clp_drop: assert property (p_clp_drop) else $error("Over-limit flagged cell kept");

  property p_phy_off;
    @(posedge clk_i) disable iff (rst_i)
      (rx_take && rx_cell_i.to_phy && !main_q[MAIN_EN_B] && !ppd_drop) |=> !rx_drop_o;
  endproperty
  a_phy_off: assert property (p_phy_off) else $error("PHY drop while disabled");

  property p_clp_flag;
    @(posedge clk_i) disable iff (rst_i)
      (rx_take && a_sdram && a_clp_hit) |=> qctl_q[$past(aq)].clp_hit;
  endproperty
  a_clp_flag: assert property (p_clp_flag) else $error("Loss-priority flag not set");

  property p_zero_lim;
    @(posedge clk_i) disable iff (rst_i)
      (rx_take && a_sdram && qfecn_q[aq] == '0) |=> qctl_q[$past(aq)].fecn_hit;
  endproperty
  a_zero_lim: assert property (p_zero_lim) else $error("Zero limit flag missed");

  property p_mark;
    @(posedge clk_i) disable iff (rst_i)
      (tx_take && d_mark) |=> tx_valid_o && tx_hdr_o[HDR_EFCI_B];
  endproperty
  a_mark: assert property (p_mark) else $error("Congested cell left unmarked");

  property p_no_mark;
    @(posedge clk_i) disable iff (rst_i)
      (tx_take && !dctl.fecn_en && !tx_cell_i.hdr[HDR_EFCI_B]) |=> !tx_hdr_o[HDR_EFCI_B];
  endproperty
  a_no_mark: assert property (p_no_mark) else $error("Marked while disabled");

  property p_ppd_set;
    @(posedge clk_i) disable iff (rst_i)
      ppd_set |=> rx_drop_o ##0 pmem[$past(ppd_ptr[12:4])][$past(ppd_ptr[3:0])];
  endproperty
  a_ppd_set: assert property (p_ppd_set) else $error("Discard state not set");

  property p_ppd_hold;
    @(posedge clk_i) disable iff (rst_i)
      (rx_take && ppd_en && ppd_state && !last_cell) |=> rx_valid_o && rx_drop_o;
  endproperty
  a_ppd_hold: assert property (p_ppd_hold) else $error("Cell of discarded packet kept");

  property p_ppd_last;
    @(posedge clk_i) disable iff (rst_i)
      (ppd_clr && !base_drop) |=> !rx_drop_o ##0 !pmem[$past(ppd_ptr[12:4])][$past(ppd_ptr[3:0])];
  endproperty
  a_ppd_last: assert property (p_ppd_last) else $error("Last cell not forwarded");

  property p_wr_dis;
    @(posedge clk_i) disable iff (rst_i)
      (rx_take && a_sdram && !actl.wr_en) |=> rx_drop_o ##0 $stable(qwr_q[$past(aq)]);
  endproperty
  a_wr_dis: assert property (p_wr_dis) else $error("Write-disabled queue stored a cell");

  property p_phy_drop;
    @(posedge clk_i) disable iff (rst_i)
      (rx_take && rx_cell_i.to_phy && main_q[MAIN_EN_B] && rh[HDR_CLP_B]
       && phy_fill_i > main_q[MAIN_LIM_W-1:0]) |=> rx_drop_o;
  endproperty
  a_phy_drop: assert property (p_phy_drop) else $error("Over-limit PHY cell kept");

  property p_zero_clp;
    @(posedge clk_i) disable iff (rst_i)
      (rx_take && a_sdram && qclp_q[aq] == '0) |=> qctl_q[$past(aq)].clp_hit;
  endproperty
  a_zero_clp: assert property (p_zero_clp) else $error("Zero loss limit flag missed");

  property p_fec_flag;
    @(posedge clk_i) disable iff (rst_i)
      (rx_take && a_sdram && a_fec_hit) |=> qctl_q[$past(aq)].fecn_hit;
  endproperty
  a_fec_flag: assert property (p_fec_flag) else $error("Congestion flag not set");

  property p_mgmt_keep;
    @(posedge clk_i) disable iff (rst_i)
      (tx_take && tx_cell_i.hdr[HDR_MGMT_B]) |=> tx_hdr_o == $past(tx_cell_i.hdr);
  endproperty
  a_mgmt_keep: assert property (p_mgmt_keep) else $error("Management cell header altered");

  property p_mark_dis;
    @(posedge clk_i) disable iff (rst_i)
      (tx_take && !dctl.fecn_en) |=> tx_hdr_o == $past(tx_cell_i.hdr);
  endproperty
  a_mark_dis: assert property (p_mark_dis) else $error("Header altered while disabled");

  property p_last_fwd;
    @(posedge clk_i) disable iff (rst_i)
      (rx_take && ppd_en && last_cell && !base_drop) |=> rx_valid_o && !rx_drop_o;
  endproperty
  a_last_fwd: assert property (p_last_fwd) else $error("Last cell of packet dropped");

  property p_sw_clear;
    @(posedge clk_i) disable iff (rst_i)
      ppd_pend_q |=> pmem[$past(ppd_addr_q[12:4])][$past(ppd_addr_q[3:0])]
                     == $past(ppd_val_q);
  endproperty
  a_sw_clear: assert property (p_sw_clear) else $error("Software state write lost");

endmodule

// >>> pkg/acd_pkg.sv
package acd_pkg;

  // Register word indices; byte address is four times the index
  localparam logic [13:0] MAIN_IDX   = 14'h0110;
  localparam logic [13:0] INFO_IDX   = 14'h0206;
  localparam logic [13:0] INFO_LAST  = 14'h0212;
  localparam logic [13:0] PWR_IDX    = 14'h0418;
  localparam logic [13:0] QCTL_IDX   = 14'h0440;
  localparam logic [13:0] QCTL_LAST  = 14'h04be;
  localparam logic [13:0] PMEM_IDX   = 14'h1000;
  localparam logic [13:0] PMEM_LAST  = 14'h13fe;
  localparam logic [13:0] QDEF_IDX   = 14'h2000;

  // Queue definition fields, eight word slots per queue
  localparam logic [2:0]  QF_BASE    = 3'h0;
  localparam logic [2:0]  QF_END     = 3'h1;
  localparam logic [2:0]  QF_CLP     = 3'h2;
  localparam logic [2:0]  QF_FECN    = 3'h3;
  localparam logic [2:0]  QF_RDP     = 3'h4;
  localparam logic [2:0]  QF_WRP     = 3'h5;

  // Main configuration fields
  localparam int          MAIN_LIM_W = 8;
  localparam int          MAIN_EN_B  = 15;
  localparam logic [15:0] MAIN_RST   = 16'h0000;

  // Discard memory write register fields
  localparam int          PW_VAL_B   = 13;
  localparam int          PW_PUL_B   = 14;

  // Header bit positions within the 64-bit bus cell header
  localparam int          HDR_CLP_B  = 0;
  localparam int          HDR_SDU_B  = 1;
  localparam int          HDR_EFCI_B = 2;
  localparam int          HDR_MGMT_B = 3;

  // Discard selectors: one enable plus thirteen pointer bits
  localparam int          SEL_W      = 6;
  localparam int          SEL_N      = 14;
  localparam int          PPD_PTR_W  = 13;
  localparam int          PMEM_WORDS = 512;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [15:0] adr;
    logic [31:0] dat;
  } acd_wb_req_type;

  typedef struct packed {
    logic [63:0] hdr;
    logic [5:0]  queue;
    logic        to_phy;
  } acd_cell_type;

  typedef struct packed {
    logic fecn_hit;
    logic clp_hit;
    logic fecn_en;
    logic clp_en;
    logic wr_en;
    logic rd_en;
  } acd_qctl_type;

endpackage

// >>> sim/acd_peer.sv
module acd_peer #(
  parameter int EN_B  = 63,
  parameter int PTR_B = 40
) (
  // System
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Cell handshake
  input  wire logic             ready_i,
  output logic                  valid_o,
  output acd_pkg::acd_cell_type cell_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import acd_pkg::*;

  initial begin
    valid_o = 1'b0;
    cell_o  = '0;
  end

  // Held until the edge that samples ready high
  task automatic send(input logic [63:0] hdr, input logic [5:0] q, input logic phy,
                      input logic pen, input logic [12:0] ptr, output bit ok);
    acd_cell_type c;
    c = '{hdr: hdr, queue: q, to_phy: phy};
    c.hdr[EN_B]        = pen;
    c.hdr[PTR_B +: 13] = ptr;
    ok = 1'b0;
    valid_o <= 1'b1;
    cell_o  <= c;
    for (int i = 0; i < 50 && !ok; i++) begin
      @(posedge clk_i);
      ok = ready_i && !rst_i;
    end
    valid_o <= 1'b0;
    // Released lines show the inverse so stale data never passes for a cell
    cell_o  <= ~c;
  endtask
endmodule

// >>> sim/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import acd_pkg::*;

  localparam logic [63:0] CLP  = 64'h1 << HDR_CLP_B;
  localparam logic [63:0] LAST = 64'h1 << HDR_SDU_B;
  localparam logic [63:0] MGMT = 64'h1 << HDR_MGMT_B;

  logic           clk_i, rst_i, wb_ack_o, rx_valid_i, rx_ready_o, rx_valid_o;
  logic           rx_drop_o, tx_valid_i, tx_ready_o, tx_valid_o;
  logic [31:0]    wb_dat_o, rd;
  logic [7:0]     phy_fill_i;
  logic [63:0]    tx_hdr_o;
  acd_wb_req_type wb_i;
  acd_cell_type   rx_cell_i, rx_cell_o, tx_cell_i;
  int             errors, num_checks;
  bit             ok;

  acd_discard i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .rx_valid_i(rx_valid_i), .rx_cell_i(rx_cell_i),
    .phy_fill_i(phy_fill_i), .rx_ready_o(rx_ready_o), .rx_valid_o(rx_valid_o),
    .rx_drop_o(rx_drop_o), .rx_cell_o(rx_cell_o), .tx_valid_i(tx_valid_i),
    .tx_cell_i(tx_cell_i), .tx_ready_o(tx_ready_o), .tx_valid_o(tx_valid_o),
    .tx_hdr_o(tx_hdr_o));

  acd_peer #(.EN_B(63), .PTR_B(40)) i_peer (.clk_i(clk_i), .rst_i(rst_i),
    .ready_i(rx_ready_o), .valid_o(rx_valid_i), .cell_o(rx_cell_i));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  function automatic logic [13:0] qd(input int q, input logic [2:0] f);
    return QDEF_IDX + 14'(q * 8) + 14'(f);
  endfunction
  function automatic logic phy_drop(input int en, input int clp, input int fill, input int lim);
    return (en != 0) && (clp != 0) && (fill > lim);
  endfunction
  function automatic logic [63:0] efci(input logic [63:0] h, input logic en, input int occ,
                                       input int thr);
    return (en && !h[HDR_MGMT_B] && occ > thr) ? (h | (64'h1 << HDR_EFCI_B)) : h;
  endfunction
  // Selector 0 is the enable bit, the rest build the pointer
  function automatic logic [31:0] sel_of(input int k);
    return (k == 0) ? 32'd63 : 32'(39 + k);
  endfunction

  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chkb(input string name, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic wb(input logic we, input logic [13:0] idx, input logic [31:0] d);
    bit got;
    got = 1'b0;
    @(posedge clk_i);
    wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: {idx, 2'b00}, dat: d};
    for (int i = 0; i < 20 && !got; i++) begin
      @(posedge clk_i);
      got = (wb_ack_o === 1'b1);
      rd  = wb_dat_o;
    end
    wb_i <= '0;
    if (!got) begin
      errors++;
      wrap_up();
    end
  endtask
  task automatic rdc(input string name, input logic [13:0] idx, input logic [31:0] exp);
    wb(1'b0, idx, 32'h0);
    chk(name, 64'(exp), 64'(rd));
  endtask
  task automatic rx(input logic [63:0] h, input logic [5:0] q, input logic phy,
                    input logic pen, input logic exp_drop);
    logic [63:0] eh;
    eh           = h;
    eh[63]       = pen;
    eh[40 +: 13] = 13'h0005;
    @(posedge clk_i);
    i_peer.send(h, q, phy, pen, 13'h0005, ok);
    if (!ok) begin
      errors++;
      wrap_up();
    end
    @(negedge clk_i);
    chkb("rx_valid", 1'b1, rx_valid_o);
    chkb("rx_drop", exp_drop, rx_drop_o);
    chk("rx_cell", eh, rx_cell_o.hdr);
  endtask
  task automatic tx(input logic [63:0] h, input logic [63:0] exp);
    bit got;
    got = 1'b0;
    @(posedge clk_i);
    tx_valid_i <= 1'b1;
    tx_cell_i  <= '{hdr: h, queue: 6'h01, to_phy: 1'b0};
    for (int i = 0; i < 20 && !got; i++) begin
      @(posedge clk_i);
      got = (tx_ready_o === 1'b1);
    end
    tx_valid_i <= 1'b0;
    if (!got) begin
      errors++;
      wrap_up();
    end
    @(negedge clk_i);
    chkb("tx_valid", 1'b1, tx_valid_o);
    chk("tx_hdr", exp, tx_hdr_o);
  endtask

  initial begin
    int en, lim, fill, clp;
    rst_i      = 1'b1;
    wb_i       = '0;
    tx_valid_i = 1'b0;
    tx_cell_i  = '0;
    phy_fill_i = 8'h00;
    errors     = 0;
    num_checks = 0;
    void'($urandom(31174));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc("main_reset", MAIN_IDX, 32'h0);
    rdc("unmapped", 14'h0100, 32'h0);
    // Selectors and the used channel's state bit before any traffic
    for (int n = 0; n < 7; n++) begin
      wb(1'b1, INFO_IDX + 14'(2 * n), sel_of(2 * n) | (sel_of(2 * n + 1) << 8));
    end
    wb(1'b1, PWR_IDX, (32'h1 << PW_PUL_B) | 32'h5);
    // Queue 1: sixteen slots holding fifteen cells, loss limit 2, congestion limit 1
    wb(1'b1, qd(1, QF_END), 32'h0000000f);
    wb(1'b1, qd(1, QF_CLP), 32'h00000002);
    wb(1'b1, qd(1, QF_FECN), 32'h00000001);
    wb(1'b1, QCTL_IDX + 14'h2, 32'h0000000f);
    for (int i = 0; i < 4; i++) rx(64'h0, 6'h01, 1'b0, 1'b0, 1'b0);
    rx(CLP, 6'h01, 1'b0, 1'b0, 1'b1);
    rdc("q1_ctl", QCTL_IDX + 14'h2, 32'h0000003f);
    rdc("q1_wr_ptr", qd(1, QF_WRP), 32'h00000004);
    tx(64'h0, efci(64'h0, 1'b1, 4, 1));
    wb(1'b1, QCTL_IDX + 14'h2, 32'h00000007);
    tx(64'h0, efci(64'h0, 1'b0, 3, 1));
    wb(1'b1, QCTL_IDX + 14'h2, 32'h0000000f);
    tx(MGMT, efci(MGMT, 1'b1, 2, 1));
    rdc("q1_rd_ptr", qd(1, QF_RDP), 32'h00000003);
    tx(64'h0, efci(64'h0, 1'b1, 1, 1));
    // Queue 3: zero limits, only read and write enabled
    wb(1'b1, qd(3, QF_END), 32'h0000000f);
    wb(1'b1, QCTL_IDX + 14'h6, 32'h00000003);
    rx(64'h0, 6'h03, 1'b0, 1'b0, 1'b0);
    rdc("q3_flags", QCTL_IDX + 14'h6, 32'h00000033);
    wb(1'b1, QCTL_IDX + 14'h6, 32'h00000033);
    rdc("q3_w1c", QCTL_IDX + 14'h6, 32'h00000003);
    rx(64'h0, 6'h02, 1'b0, 1'b0, 1'b1);
    // Fill around the limit to hit the equal case often
    for (int i = 0; i < 24; i++) begin
      en   = int'($urandom % 2);
      lim  = int'($urandom_range(254, 1));
      fill = lim - 1 + int'($urandom % 3);
      clp  = int'($urandom % 2);
      wb(1'b1, MAIN_IDX, 32'((en << MAIN_EN_B) | lim));
      phy_fill_i <= 8'(fill);
      rx((clp != 0) ? CLP : 64'h0, 6'h00, 1'b1, 1'b0, phy_drop(en, clp, fill, lim));
    end
    wb(1'b1, MAIN_IDX, 32'h00008004);
    phy_fill_i <= 8'h05;
    rx(CLP, 6'h00, 1'b1, 1'b1, 1'b1);
    wb(1'b0, PMEM_IDX, 32'h0);
    chkb("state_set", 1'b1, rd[5]);
    phy_fill_i <= 8'h00;
    rx(64'h0, 6'h00, 1'b1, 1'b1, 1'b1);
    rx(LAST, 6'h00, 1'b1, 1'b1, 1'b0);
    wb(1'b0, PMEM_IDX, 32'h0);
    chkb("state_clear", 1'b0, rd[5]);
    rx(64'h0, 6'h00, 1'b1, 1'b1, 1'b0);
    wrap_up();
  end
endmodule
